// ===== logic/spp_pkg.sv
// Shared constants and carrier types for the strobed parallel port.
// Assumes a single 25 MHz clock and an AXI4-Lite master with 32-bit data.
package spp_pkg;

   // Register indices; byte address is four times the index
   localparam logic [1:0] IDX_PORT_A = 2'h0;
   localparam logic [1:0] IDX_PORT_B = 2'h1;
   localparam logic [1:0] IDX_PORT_C = 2'h2;
   localparam logic [1:0] IDX_CONFIG = 2'h3;
   localparam int ADDR_LSB = 2;
   localparam int ADDR_MAP_TOP = 4;

   // Reset value of the configuration byte: every port an input
   localparam logic [7:0] CFG_RESET = 8'h9B;

   // Status word and Port C line positions
   localparam int ST_OUT_FULL_N = 7;
   localparam int ST_OUT_IRQ_EN = 6;
   localparam int ST_IN_FULL = 5;
   localparam int ST_IN_IRQ_EN = 4;
   localparam int ST_IRQ_REQ = 3;
   localparam int ST_B_IRQ_EN = 2;
   localparam int ST_B_OUT_FULL_N = 1;
   localparam int ST_B_IRQ_REQ = 0;
   localparam int PIN_A_ACK_N = 6;
   localparam int PIN_A_STB_N = 4;
   localparam int PIN_B_ACK_N = 2;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Group A operating modes
   typedef enum logic [1:0] {AM_SIMPLE, AM_STROBE_OUT, AM_BIDIR} spp_amode_e;

   // Configuration byte layout
   typedef struct packed {
      logic mode_set;      // 1 = mode word, 0 = Port C bit set/reset
      logic [1:0] a_mode;  // 00 simple, 01 strobed, 1x bidirectional
      logic a_in;          // Port A direction, 1 = input
      logic cu_in;         // Port C upper nibble direction
      logic b_mode;        // 0 simple, 1 strobed
      logic b_in;          // Port B direction
      logic cl_in;         // Port C lower nibble direction
   } spp_cfg_s;

   // One bundle of peripheral lines
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] c;
   } spp_pins_s;

endpackage : spp_pkg

// ===== logic/spp_parallel_port.sv
// Host-programmed parallel port: strobed output on A and B, bidirectional A.
// Assumes peripheral lines are synchronous to aclk; handshake inputs active low.
//
// How it works
// - Config byte 0xA0 selects strobed output on A
// - Config byte 0x84 selects strobed output on B
// - Bidirectional A carries both directions, no reconfiguring
// - Port B stays independently configurable meanwhile
// - Bidirectional only for Port A group
// - Five C lines control; A data latched
// - Bidirectional transfers paced by C handshakes
// - Port C read returns handshake status word
// - Bit 7 output full, low after write
// - Bit 6 output irq enable, line six
// - Bit 5 input full after peripheral capture
// - Bit 4 input irq enable, line four
// - Bit 3 request from enabled buffer conditions
// - C bits 2..0 extra I/O unless B strobed
// - Simple B frees C lines two..zero
`timescale 1ns/1ps
module spp_parallel_port #(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,                      // 25 MHz clock
   input wire logic aresetn,                   // Synchronous reset, active low
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid,             // Write address valid
   output logic s_axi_awready,                 // Write address ready
   input wire logic [31:0] s_axi_wdata,        // Write data
   input wire logic [3:0] s_axi_wstrb,         // Byte enables
   input wire logic s_axi_wvalid,              // Write data valid
   output logic s_axi_wready,                  // Write data ready
   output logic [1:0] s_axi_bresp,             // Write response
   output logic s_axi_bvalid,                  // Write response valid
   input wire logic s_axi_bready,              // Write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid,             // Read address valid
   output logic s_axi_arready,                 // Read address ready
   output logic [31:0] s_axi_rdata,            // Read data
   output logic [1:0] s_axi_rresp,             // Read response
   output logic s_axi_rvalid,                  // Read data valid
   input wire logic s_axi_rready,              // Read data ready
   input wire spp_pkg::spp_pins_s pin_in,      // Peripheral line levels
   output spp_pkg::spp_pins_s pin_out,         // Peripheral line drive values
   output spp_pkg::spp_pins_s pin_oe           // High where the port drives
);

   // Address must cover the four register words
   if (ADDR_W < spp_pkg::ADDR_MAP_TOP)
   begin : g_bad_addr
      $error("ADDR_W too small for the register map");
   end

   // Register hit: inside the map; the two low address bits are not checked
   function automatic logic spp_hit(input logic [ADDR_W-1:0] addr);
      spp_hit = (addr >> spp_pkg::ADDR_MAP_TOP) == '0;
   endfunction : spp_hit

   spp_pkg::spp_cfg_s cfg_ff;
   spp_pkg::spp_amode_e amode;
   logic [7:0] pa_out_ff;
   logic [7:0] pa_in_ff;
   logic [7:0] pb_out_ff;
   logic [7:0] pc_latch_ff;
   logic port_a_out_full_n_ff;
   logic port_b_out_full_n_ff;
   logic ibf_ff;
   logic a_ack_d_ff;
   logic a_stb_d_ff;
   logic b_ack_d_ff;
   logic aw_hold_ff;
   logic w_hold_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic [7:0] wdata_ff;
   logic wstrb0_ff;
   logic b_strobe_out;
   logic a_handshake;
   logic a_ack_fall;
   logic a_stb_fall;
   logic b_ack_fall;
   logic irq_a;
   logic irq_b;
   logic do_write;
   logic wr_en;
   logic [1:0] wr_idx;
   logic rd_hs;
   logic rd_a;
   logic [7:0] nxt_c_out;
   logic [7:0] nxt_c_oe;
   logic [7:0] status;
   logic [7:0] rd_value;
   spp_pkg::spp_pins_s nxt_pin_out;
   spp_pkg::spp_pins_s nxt_pin_oe;

   // Group A mode; only group A offers the bidirectional bus
   always_comb
   begin
      if (cfg_ff.a_mode[1])
         amode = spp_pkg::AM_BIDIR;
      else if (cfg_ff.a_mode == 2'b01 && !cfg_ff.a_in)
         amode = spp_pkg::AM_STROBE_OUT;
      else
         amode = spp_pkg::AM_SIMPLE;
   end

   // Group B decoded on its own bits whatever group A does
   assign b_strobe_out = cfg_ff.b_mode && !cfg_ff.b_in;
   assign a_handshake = amode != spp_pkg::AM_SIMPLE;

   // Handshake edges; inputs are synchronous so one stage suffices
   assign a_ack_fall = a_ack_d_ff && !pin_in.c[spp_pkg::PIN_A_ACK_N];
   assign a_stb_fall = a_stb_d_ff && !pin_in.c[spp_pkg::PIN_A_STB_N];
   assign b_ack_fall = b_ack_d_ff && !pin_in.c[spp_pkg::PIN_B_ACK_N];

   // Interrupt requests from enabled buffer conditions
   assign irq_a = a_handshake
      && ((pc_latch_ff[spp_pkg::ST_OUT_IRQ_EN] && port_a_out_full_n_ff)
      || (amode == spp_pkg::AM_BIDIR && pc_latch_ff[spp_pkg::ST_IN_IRQ_EN] && ibf_ff));
   assign irq_b = b_strobe_out && pc_latch_ff[spp_pkg::ST_B_IRQ_EN] && port_b_out_full_n_ff;

   // Bus side decode
   assign do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
   assign wr_idx = awaddr_ff[spp_pkg::ADDR_LSB +: 2];
   assign wr_en = do_write && wstrb0_ff && spp_hit(awaddr_ff);
   assign rd_hs = s_axi_arvalid && s_axi_arready;
   assign rd_a = rd_hs && spp_hit(s_axi_araddr)
      && s_axi_araddr[spp_pkg::ADDR_LSB +: 2] == spp_pkg::IDX_PORT_A;

   // Port C line roles and the status word built from them
   always_comb
   begin
      nxt_c_out = pc_latch_ff;
      nxt_c_oe = {{4{!cfg_ff.cu_in}}, {4{!cfg_ff.cl_in}}};
      if (a_handshake)
      begin
         nxt_c_out[spp_pkg::ST_OUT_FULL_N] = port_a_out_full_n_ff;
         nxt_c_oe[spp_pkg::ST_OUT_FULL_N] = 1'b1;
         nxt_c_oe[spp_pkg::PIN_A_ACK_N] = 1'b0;
         nxt_c_out[spp_pkg::ST_IRQ_REQ] = irq_a;
         nxt_c_oe[spp_pkg::ST_IRQ_REQ] = 1'b1;
      end
      if (amode == spp_pkg::AM_BIDIR)
      begin
         nxt_c_out[spp_pkg::ST_IN_FULL] = ibf_ff;
         nxt_c_oe[spp_pkg::ST_IN_FULL] = 1'b1;
         nxt_c_oe[spp_pkg::PIN_A_STB_N] = 1'b0;
      end
      // Lower lines stay extra I/O unless B takes them for handshakes
      if (b_strobe_out)
      begin
         nxt_c_out[spp_pkg::ST_B_OUT_FULL_N] = port_b_out_full_n_ff;
         nxt_c_oe[spp_pkg::ST_B_OUT_FULL_N] = 1'b1;
         nxt_c_oe[spp_pkg::PIN_B_ACK_N] = 1'b0;
         nxt_c_out[spp_pkg::ST_B_IRQ_REQ] = irq_b;
         nxt_c_oe[spp_pkg::ST_B_IRQ_REQ] = 1'b1;
      end
      // Status: driven lines read the latch, others the pins
      status = (pin_in.c & ~nxt_c_oe) | (pc_latch_ff & nxt_c_oe);
      if (a_handshake)
      begin
         status[spp_pkg::ST_OUT_FULL_N] = port_a_out_full_n_ff;
         status[spp_pkg::ST_OUT_IRQ_EN] = pc_latch_ff[spp_pkg::ST_OUT_IRQ_EN];
         status[spp_pkg::ST_IRQ_REQ] = irq_a;
      end
      if (amode == spp_pkg::AM_BIDIR)
      begin
         status[spp_pkg::ST_IN_FULL] = ibf_ff;
         status[spp_pkg::ST_IN_IRQ_EN] = pc_latch_ff[spp_pkg::ST_IN_IRQ_EN];
      end
      if (b_strobe_out)
      begin
         status[spp_pkg::ST_B_IRQ_EN] = pc_latch_ff[spp_pkg::ST_B_IRQ_EN];
         status[spp_pkg::ST_B_OUT_FULL_N] = port_b_out_full_n_ff;
         status[spp_pkg::ST_B_IRQ_REQ] = irq_b;
      end
   end

   // Pin drive; A in bidirectional mode only during acknowledge
   always_comb
   begin
      nxt_pin_out.a = pa_out_ff;
      nxt_pin_out.b = pb_out_ff;
      nxt_pin_out.c = nxt_c_out;
      if (amode == spp_pkg::AM_BIDIR)
         nxt_pin_oe.a = {8{!pin_in.c[spp_pkg::PIN_A_ACK_N]}};
      else
         nxt_pin_oe.a = {8{!cfg_ff.a_in}};
      nxt_pin_oe.b = {8{!cfg_ff.b_in}};
      nxt_pin_oe.c = nxt_c_oe;
   end

   // Read mux; the configuration register is write-only and reads zero
   always_comb
   begin
      rd_value = 8'h00;
      unique case (s_axi_araddr[spp_pkg::ADDR_LSB +: 2])
         spp_pkg::IDX_PORT_A:
            if (amode == spp_pkg::AM_BIDIR)
               rd_value = pa_in_ff;
            else if (cfg_ff.a_in)
               rd_value = pin_in.a;
            else
               rd_value = pa_out_ff;
         spp_pkg::IDX_PORT_B:
            rd_value = cfg_ff.b_in ? pin_in.b : pb_out_ff;
         spp_pkg::IDX_PORT_C:
            rd_value = status;
         spp_pkg::IDX_CONFIG:
            rd_value = 8'h00;
      endcase
   end

   // Configuration word; bit 7 low is a Port C bit command instead
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cfg_ff <= spp_pkg::CFG_RESET;
      else if (wr_en && wr_idx == spp_pkg::IDX_CONFIG && wdata_ff[7])
         cfg_ff <= wdata_ff;
   end

   // Port C latch holds extra outputs and the three interrupt enables
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pc_latch_ff <= 8'h00;
      else if (wr_en && wr_idx == spp_pkg::IDX_CONFIG)
      begin
         if (wdata_ff[7])
            pc_latch_ff <= 8'h00;
         else
            pc_latch_ff[wdata_ff[3:1]] <= wdata_ff[0];
      end
      else if (wr_en && wr_idx == spp_pkg::IDX_PORT_C)
         pc_latch_ff <= wdata_ff;
   end

   // Output data latches
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pa_out_ff <= 8'h00;
         pb_out_ff <= 8'h00;
      end
      else if (wr_en)
      begin
         if (wr_idx == spp_pkg::IDX_PORT_A)
            pa_out_ff <= wdata_ff;
         if (wr_idx == spp_pkg::IDX_PORT_B)
            pb_out_ff <= wdata_ff;
      end
   end

   // A output full; acknowledge wins over a simultaneous write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         port_a_out_full_n_ff <= 1'b1;
      else if (wr_en && wr_idx == spp_pkg::IDX_CONFIG && wdata_ff[7])
         port_a_out_full_n_ff <= 1'b1;
      else if (a_handshake && a_ack_fall)
         port_a_out_full_n_ff <= 1'b1;
      else if (a_handshake && wr_en && wr_idx == spp_pkg::IDX_PORT_A)
         port_a_out_full_n_ff <= 1'b0;
   end

   // B output full, same handshake as A
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         port_b_out_full_n_ff <= 1'b1;
      else if (wr_en && wr_idx == spp_pkg::IDX_CONFIG && wdata_ff[7])
         port_b_out_full_n_ff <= 1'b1;
      else if (b_strobe_out && b_ack_fall)
         port_b_out_full_n_ff <= 1'b1;
      else if (b_strobe_out && wr_en && wr_idx == spp_pkg::IDX_PORT_B)
         port_b_out_full_n_ff <= 1'b0;
   end

   // A input latch; a strobe wins over the clearing read
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ibf_ff <= 1'b0;
         pa_in_ff <= 8'h00;
      end
      else if (wr_en && wr_idx == spp_pkg::IDX_CONFIG && wdata_ff[7])
         ibf_ff <= 1'b0;
      else if (amode == spp_pkg::AM_BIDIR && a_stb_fall)
      begin
         ibf_ff <= 1'b1;
         pa_in_ff <= pin_in.a;
      end
      else if (amode == spp_pkg::AM_BIDIR && rd_a)
         ibf_ff <= 1'b0;
   end

   // Previous handshake levels, idle high
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         a_ack_d_ff <= 1'b1;
         a_stb_d_ff <= 1'b1;
         b_ack_d_ff <= 1'b1;
      end
      else
      begin
         a_ack_d_ff <= pin_in.c[spp_pkg::PIN_A_ACK_N];
         a_stb_d_ff <= pin_in.c[spp_pkg::PIN_A_STB_N];
         b_ack_d_ff <= pin_in.c[spp_pkg::PIN_B_ACK_N];
      end
   end

   // Registered pins so every output comes from a flop
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_out <= '0;
         pin_oe <= '0;
      end
      else
      begin
         pin_out <= nxt_pin_out;
         pin_oe <= nxt_pin_oe;
      end
   end

   // Write channels taken in either order; response after both
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= 8'h00;
         wstrb0_ff <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= spp_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_ff <= 1'b1;
            wdata_ff <= s_axi_wdata[7:0];
            wstrb0_ff <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (do_write)
         begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= spp_hit(awaddr_ff) ? spp_pkg::RESP_OKAY : spp_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Read channel; data sampled at the address handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= spp_pkg::RESP_OKAY;
      end
      else if (rd_hs)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         if (spp_hit(s_axi_araddr))
         begin
            s_axi_rdata <= {24'h00_0000, rd_value};
            s_axi_rresp <= spp_pkg::RESP_OKAY;
         end
         else
         begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= spp_pkg::RESP_SLVERR;
         end
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule : spp_parallel_port

// ===== verification/spp_parallel_port_asserts.sv
// Checker for the parallel port: bus answer timing, flags, line drive.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module spp_parallel_port_asserts #(
   parameter int ADDR_W = 8
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset
   input wire logic s_axi_awvalid, // AW valid
   input wire logic s_axi_awready, // AW ready
   input wire logic s_axi_wvalid, // W valid
   input wire logic s_axi_wready, // W ready
   input wire logic s_axi_bvalid, // B valid
   input wire logic [ADDR_W-1:0] s_axi_araddr, // AR address
   input wire logic s_axi_arvalid, // AR valid
   input wire logic s_axi_arready, // AR ready
   input wire logic [31:0] s_axi_rdata, // R data
   input wire logic [1:0] s_axi_rresp, // R response
   input wire logic s_axi_rvalid, // R valid
   input wire spp_pkg::spp_pins_s pin_in, // Line levels
   input wire spp_pkg::spp_pins_s pin_out, // Drive values
   input wire spp_pkg::spp_pins_s pin_oe // Drive enables
);
   logic rd_c_ff; // Read in flight hits the status word
   logic hs_a; // Port A handshakes, ack is an input
   logic bidir; // Strobe input, in-full output
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Remember the target of each read
   always_ff @(posedge aclk)
   begin
      if (s_axi_arvalid && s_axi_arready) rd_c_ff <= s_axi_araddr[3:2] == spp_pkg::IDX_PORT_C;
   end
   // Mode seen from the enables alone; no config port to watch
   assign hs_a = pin_oe.c[7] && !pin_oe.c[6];
   assign bidir = hs_a && pin_oe.c[5] && !pin_oe.c[4];
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_ack_fall;
      hs_a && $fell(pin_in.c[6]);
   endsequence
   property p_b_time;
      s_wr_take |-> !s_axi_bvalid ##1 !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_b_time: assert property (p_b_time) else $error("write answer late");
   property p_r_time;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_time: assert property (p_r_time) else $error("read answer late");
   property p_slverr;
      s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:4] != '0
         |=> s_axi_rresp == spp_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped read answered");
   property p_out_fall;
      $fell(pin_out.c[7]) && hs_a |-> $past(s_axi_bvalid);
   endproperty
   a_out_fall: assert property (p_out_fall) else $error("full flag fell without write");
   property p_ack_ret;
      s_ack_fall |-> ##[2:3] pin_out.c[7];
   endproperty
   a_ack_ret: assert property (p_ack_ret) else $error("ack did not free buffer");
   property p_a_drive;
      bidir && !pin_in.c[6] |=> pin_oe.a == 8'hFF;
   endproperty
   a_a_drive: assert property (p_a_drive) else $error("port A not driven on ack");
   property p_in_full;
      bidir && $fell(pin_in.c[4]) |-> ##[2:3] pin_out.c[5];
   endproperty
   a_in_full: assert property (p_in_full) else $error("strobe did not fill input");
   property p_irq;
      s_axi_rvalid && rd_c_ff && hs_a && pin_oe.c[3] |-> s_axi_rdata[3] ==
         (s_axi_rdata[7] && s_axi_rdata[6] || bidir && s_axi_rdata[5] && s_axi_rdata[4]);
   endproperty
   a_irq: assert property (p_irq) else $error("request bit wrong");
endmodule : spp_parallel_port_asserts
bind spp_parallel_port spp_parallel_port_asserts #(.ADDR_W(ADDR_W)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
);

// ===== verification/spp_periph_model.sv
// Peripheral model: acknowledges output bytes and strobes input bytes.
// Assumes lines synchronous to aclk, handshake lines active low.
`timescale 1ns/1ps
module spp_periph_model (
   input wire logic aclk, // Clock
   input wire spp_pkg::spp_pins_s pin_out, // Port drive values
   input wire spp_pkg::spp_pins_s pin_oe, // Port drive enables
   output spp_pkg::spp_pins_s pin_in // Resolved line levels
);
   logic [7:0] hs_n = 8'hFF; // Ack and strobe lines, idle high
   logic [7:0] flt_ff = 8'h5A; // Level of released lines
   logic [7:0] stb_val = 8'h00;
   logic stb_drv = 1'b0;
   // Released lines change every cycle so stale data never matches
   always_ff @(posedge aclk)
   begin
      flt_ff <= ~flt_ff;
   end
   // Port value where it drives, else the model's own level
   assign pin_in.a = (pin_oe.a & pin_out.a) | (~pin_oe.a & (stb_drv ? stb_val : flt_ff));
   assign pin_in.b = (pin_oe.b & pin_out.b) | (~pin_oe.b & flt_ff);
   assign pin_in.c = (pin_oe.c & pin_out.c) | (~pin_oe.c & ((hs_n & 8'h54) | (flt_ff & 8'hAB)));
   // Two-cycle ack after a chosen delay; byte taken at its end
   task automatic ack(input int ln, input int dly, output logic [7:0] got);
      repeat (dly) @(posedge aclk);
      hs_n[ln] <= 1'b0;
      repeat (2) @(posedge aclk);
      got = (ln == 6) ? pin_in.a : pin_in.b;
      hs_n[ln] <= 1'b1;
   endtask : ack
   // One strobe cycle, data held one cycle past it
   task automatic strobe(input logic [7:0] d);
      stb_val <= d;
      stb_drv <= 1'b1;
      hs_n[4] <= 1'b0;
      @(posedge aclk);
      hs_n[4] <= 1'b1;
      @(posedge aclk);
      stb_drv <= 1'b0;
   endtask : strobe
endmodule : spp_periph_model

// ===== verification/spp_parallel_port_tb_top.sv
// Bench for the parallel port: bus master tasks, one task per scenario.
// Assumes the peripheral model on the lines and the checker bound in.
`timescale 1ns/1ps
module spp_parallel_port_tb_top;
   localparam logic [7:0] AD_A = {4'h0, spp_pkg::IDX_PORT_A, 2'h0};
   localparam logic [7:0] AD_B = {4'h0, spp_pkg::IDX_PORT_B, 2'h0};
   localparam logic [7:0] AD_C = {4'h0, spp_pkg::IDX_PORT_C, 2'h0};
   localparam logic [7:0] AD_F = {4'h0, spp_pkg::IDX_CONFIG, 2'h0};
   logic aclk;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic arvalid = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] st, got;
   spp_pkg::spp_pins_s pin_in, pin_out, pin_oe;
   int num_errors = 0;
   int tests_run = 0;
   // Clock at 25 MHz
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // Byte lanes, bready and rready tied: master always accepts answers
   spp_parallel_port u_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
   );
   spp_periph_model u_per (
      .aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in)
   );
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] ad, input logic [7:0] d,
      input logic [1:0] er = spp_pkg::RESP_OKAY);
      awaddr <= ad;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      chk({6'h00, bresp}, {6'h00, er});
   endtask : wr
   task automatic rd(input logic [7:0] ad, output logic [7:0] d);
      araddr <= ad;
      arvalid <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata[7:0];
   endtask : rd
   task automatic settle;
      repeat (2) @(posedge aclk);
   endtask : settle
   // Bounded status poll; caller judges the flag
   task automatic poll(input logic [7:0] m);
      int n;
      n = 0;
      rd(AD_C, st);
      while (!(st & m) && n < 50)
      begin
         rd(AD_C, st);
         n++;
      end
   endtask : poll
   task automatic t_map;
      rd(AD_F, got);
      chk(got, 8'h00);
      rd(8'h10, got);
      chk({6'h00, rresp}, {6'h00, spp_pkg::RESP_SLVERR});
      chk(got, 8'h00);
      wr(8'h20, 8'h5A, spp_pkg::RESP_SLVERR);
      settle;
      chk(pin_oe.a, 8'h00);
      chk(pin_out.a, 8'h00);
      $display("test map done");
   endtask : t_map
   task automatic t_a_out;
      wr(AD_F, 8'hA0);
      wr(AD_F, 8'h0D);
      settle;
      chk(pin_oe.a, 8'hFF);
      wr(AD_A, 8'h12);
      rd(AD_C, st);
      chk(st & 8'hC8, 8'h40);
      fork
         u_per.ack(6, 4, got);
         poll(8'h80);
      join
      chk(got, 8'h12);
      chk(st & 8'hC8, 8'hC8);
      wr(AD_A, 8'h34);
      u_per.ack(6, 0, got);
      chk(got, 8'h34);
      wr(AD_F, 8'h0C);
      rd(AD_C, st);
      chk(st & 8'hC8, 8'h80);
      $display("test port A strobed done");
   endtask : t_a_out
   task automatic t_b_out;
      wr(AD_F, 8'h84);
      wr(AD_F, 8'h05);
      wr(AD_B, 8'h34);
      rd(AD_C, st);
      chk(st & 8'h07, 8'h04);
      fork
         u_per.ack(2, 3, got);
         poll(8'h02);
      join
      chk(got, 8'h34);
      chk(st & 8'h07, 8'h07);
      $display("test port B strobed done");
   endtask : t_b_out
   task automatic t_bidir;
      wr(AD_F, 8'hC0);
      wr(AD_C, 8'h55);
      wr(AD_B, 8'h77);
      settle;
      chk({5'h00, pin_out.c[2:0]}, 8'h05);
      chk({5'h00, pin_oe.c[2:0]}, 8'h07);
      chk(pin_out.b, 8'h77);
      chk(pin_oe.a, 8'h00);
      rd(AD_C, st);
      chk(st, 8'hDD);
      wr(AD_A, 8'h5A);
      rd(AD_C, st);
      chk(st, 8'h55);
      u_per.strobe(8'hC3);
      rd(AD_C, st);
      chk(st, 8'h7D);
      rd(AD_A, got);
      chk(got, 8'hC3);
      rd(AD_C, st);
      chk(st, 8'h55);
      u_per.ack(6, 2, got);
      chk(got, 8'h5A);
      settle;
      chk(pin_oe.a, 8'h00);
      wr(AD_F, 8'hC4);
      wr(AD_B, 8'h66);
      rd(AD_C, st);
      chk(st & 8'h07, 8'h00);
      chk({5'h00, pin_oe.c[2:0]}, 8'h03);
      $display("test bidirectional done");
   endtask : t_bidir
   task automatic results;
      $display("checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results
   // Reset for two cycles, then the scenarios
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_map;
      t_a_out;
      t_b_out;
      t_bidir;
      results;
   end
   // Hang guard; the run needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge aclk);
      num_errors++;
      results;
   end
endmodule : spp_parallel_port_tb_top
